// [rtl/api_response_frame_builder.sv]
// Functional notes
// [R1] Frame opens 0x7E, two-byte length MSB first, then the frame type byte.
// [R2] Node identification frame puts fixed maker code at offsets 33-34 before checksum.
// [R3] Reply to an earlier remote command request goes out as a type 0x97 frame.
// [R4] Offset 4 of the response echoes the frame identifier of the request.
// [R5] Offsets 5-12 hold the answering device 64-bit address, MSB first.
// [R6] Offsets 13-14 hold its 16-bit address, or 0xFFFE when unknown.
// [R7] Offsets 15-16 echo the two-character command name.
// [R8] Status at offset 17: 0 ok, 1 error, 2 bad command, 3 bad parameter, 4 tx fail.
// [R9] Query data follows from offset 18; a register write carries none.
// [R10] One request may yield several responses sharing one frame identifier.
// [R11] Type 0x98 trace frames only go out while the verbose-join option is on.
// [R12] Trace frames are suppressed in command mode on the newer behaviour.
// [R13] Trace frame carries status code at offset 4, code-dependent data from 5.
// [R14] Code 0x00 marks a join attempt start, one byte of attempt count.
// [R15] Checksum is 0xFF minus low byte of sum from frame type to last data.
`timescale 1ns/10ps
`include "frame_builder_defs.svh"
module api_response_frame_builder (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rsp_valid_in,
    output logic rsp_ready_out,
    input wire frame_builder_pkg::remote_rsp_t rsp_in,
    input wire logic ext_valid_in,
    output logic ext_ready_out,
    input wire frame_builder_pkg::ext_status_t ext_in,
    input wire logic node_valid_in,
    output logic node_ready_out,
    input wire frame_builder_pkg::node_id_t node_in,
    input wire logic verbose_join_option_in,
    input wire logic command_mode_in,
    input wire logic suppress_in_cmd_mode_in,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    output logic [7:0] tx_data_out,
    output logic ext_dropped_out
);
    import frame_builder_pkg::*;

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HDR = 4'b0010,
        ST_BODY = 4'b0100,
        ST_CKSUM = 4'b1000
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic [7:0] body_reg [36];
    logic [5:0] body_len_reg;
    logic [5:0] idx_reg;
    logic [7:0] sum_reg;
    logic fifo_in_ready;
    logic [7:0] fifo_byte;
    logic ext_dropped_reg;

    function automatic logic [7:0] byte_of(input logic [127:0] d, input int i);
        byte_of = d[127-8*i -: 8];
    endfunction : byte_of

    function automatic logic [5:0] body_len(input logic [5:0] fixed, input logic [4:0] n);
        body_len = 6'(fixed + {1'b0, n});
    endfunction : body_len

    wire idle = (state_reg == ST_IDLE);
    wire ext_allowed = verbose_join_option_in && !(suppress_in_cmd_mode_in && command_mode_in); // [R11] [R12]
    wire take_node = idle && node_valid_in;
    wire take_rsp = idle && !node_valid_in && rsp_valid_in; // [R3] [R10]
    wire take_ext = idle && !node_valid_in && !rsp_valid_in && ext_valid_in && ext_allowed;
    wire drop_ext = idle && !node_valid_in && !rsp_valid_in && ext_valid_in && !ext_allowed;
    wire [4:0] rsp_n = (rsp_in.data_len > `FB_MAX_PAYLOAD) ? `FB_MAX_PAYLOAD : rsp_in.data_len;
    wire [4:0] ext_n = (ext_in.data_len > `FB_MAX_PAYLOAD) ? `FB_MAX_PAYLOAD : ext_in.data_len;
    wire [15:0] rsp_addr16 = rsp_in.addr16_known ? rsp_in.addr16 : `FB_NET_ADDR_UNKNOWN; // [R6]
    function automatic logic tx_advance(input logic rdy, input state_t st);
        tx_advance = rdy && (st != ST_IDLE);
    endfunction : tx_advance

    wire fire = tx_advance(fifo_in_ready, state_reg);
    wire [15:0] len_field = {10'h000, body_len_reg};

    assign node_ready_out = idle;
    assign rsp_ready_out = idle && !node_valid_in;
    assign ext_ready_out = idle && !node_valid_in && !rsp_valid_in;
    assign ext_dropped_out = ext_dropped_reg;

    always_ff @(posedge clk_in) begin
        if (take_node) begin
            body_reg[0] <= `FB_TYPE_NODE_ID;
            for (int i = 0; i < 8; i++) begin
                body_reg[1+i] <= node_in.addr64[63-8*i -: 8];
                body_reg[14+i] <= node_in.remote64[63-8*i -: 8];
            end
            body_reg[9] <= node_in.addr16[15:8];
            body_reg[10] <= node_in.addr16[7:0];
            body_reg[11] <= node_in.rx_opts;
            body_reg[12] <= node_in.remote16[15:8];
            body_reg[13] <= node_in.remote16[7:0];
            body_reg[22] <= node_in.name[15:8];
            body_reg[23] <= node_in.name[7:0];
            body_reg[24] <= node_in.parent16[15:8];
            body_reg[25] <= node_in.parent16[7:0];
            body_reg[26] <= node_in.dev_type;
            body_reg[27] <= node_in.src_event;
            body_reg[28] <= node_in.profile[15:8];
            body_reg[29] <= node_in.profile[7:0];
            body_reg[30] <= 8'(`FB_MAKER_CODE >> 8); // [R2]
            body_reg[31] <= 8'(`FB_MAKER_CODE); // [R2]
        end else if (take_rsp) begin
            body_reg[0] <= `FB_TYPE_REMOTE_RSP; // [R3]
            body_reg[1] <= rsp_in.frame_id; // [R4]
            for (int i = 0; i < 8; i++) begin
                body_reg[2+i] <= rsp_in.addr64[63-8*i -: 8]; // [R5]
            end
            body_reg[10] <= rsp_addr16[15:8]; // [R6]
            body_reg[11] <= rsp_addr16[7:0];
            body_reg[12] <= rsp_in.cmd_name[15:8]; // [R7]
            body_reg[13] <= rsp_in.cmd_name[7:0];
            body_reg[14] <= rsp_in.status; // [R8]
            for (int i = 0; i < 16; i++) begin
                body_reg[15+i] <= byte_of(rsp_in.data, i); // [R9]
            end
        end else if (take_ext) begin
            body_reg[0] <= `FB_TYPE_EXT_STATUS; // [R11]
            body_reg[1] <= ext_in.code; // [R13] [R14]
            for (int i = 0; i < 16; i++) begin
                body_reg[2+i] <= byte_of(ext_in.data, i); // [R13]
            end
        end
    end

    // ------------------------------------------------------------
    // Serializer
    // ------------------------------------------------------------
    wire hdr_last = (idx_reg == 6'(`FB_HDR_LEN - 6'd2));
    wire body_last = (idx_reg == 6'(body_len_reg - 6'd1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take_node || take_rsp || take_ext) begin
                    state_next = ST_HDR;
                end
            end
            ST_HDR: begin
                if (fire && hdr_last) begin
                    state_next = ST_BODY;
                end
            end
            ST_BODY: begin
                if (fire && body_last) begin
                    state_next = ST_CKSUM;
                end
            end
            ST_CKSUM: begin
                if (fire) begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    // Header bytes: delimiter then length MSB, LSB
    wire [7:0] hdr_byte = (idx_reg == 6'd0) ? `FB_DELIM :
        (idx_reg == 6'd1) ? len_field[15:8] : len_field[7:0]; // [R1]
    wire [7:0] cur_byte = (state_reg == ST_HDR) ? hdr_byte :
        (state_reg == ST_BODY) ? body_reg[idx_reg] :
        8'(`FB_CKSUM_BASE - sum_reg); // [R15]

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
            idx_reg <= '0;
            body_len_reg <= '0;
            sum_reg <= '0;
            ext_dropped_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ext_dropped_reg <= drop_ext;
            if (take_node) begin
                body_len_reg <= `FB_NODE_ID_BODY_LEN + 6'd3;
            end else if (take_rsp) begin
                body_len_reg <= body_len(`FB_RSP_FIXED_LEN, rsp_n); // [R9]
            end else if (take_ext) begin
                body_len_reg <= body_len(`FB_EXT_FIXED_LEN, ext_n);
            end
            if (idle) begin
                idx_reg <= '0;
                sum_reg <= '0;
            end else if (fire) begin
                if ((state_reg == ST_HDR && hdr_last) || state_reg == ST_BODY && body_last) begin
                    idx_reg <= '0;
                end else begin
                    idx_reg <= 6'(idx_reg + 6'd1);
                end
                if (state_reg == ST_BODY) begin
                    sum_reg <= 8'(sum_reg + body_reg[idx_reg]); // [R15]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    byte_fifo #(.WIDTH(8), .DEPTH(`FB_FIFO_DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(state_reg != ST_IDLE),
        .in_ready_out(fifo_in_ready),
        .in_data_in(cur_byte),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in),
        .out_data_out(fifo_byte)
    );
    assign tx_data_out = fifo_byte;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_FIRST_DELIM: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
        (state_reg == ST_HDR && idx_reg == 6'd0) |-> cur_byte == `FB_DELIM)
        else $error("frame does not open with delimiter");
    AST_HDR_TO_BODY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R1]
        (state_reg == ST_HDR && fire && hdr_last) |=> state_reg == ST_BODY && idx_reg == 6'd0)
        else $error("header length wrong");
    AST_RSP_TYPE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R3]
        take_rsp |=> body_reg[0] == `FB_TYPE_REMOTE_RSP && state_reg == ST_HDR)
        else $error("response frame type wrong");
    AST_RSP_ID: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R4]
        take_rsp |=> body_reg[1] == $past(rsp_in.frame_id))
        else $error("frame id not echoed");
    AST_RSP_ADDR16: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R6]
        (take_rsp && !rsp_in.addr16_known) |=> {body_reg[10], body_reg[11]} == `FB_NET_ADDR_UNKNOWN)
        else $error("unknown address not 0xFFFE");
    AST_RSP_LEN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R9]
        take_rsp |=> body_len_reg == 6'(`FB_RSP_FIXED_LEN + $past(rsp_n)))
        else $error("response length wrong");
    AST_EXT_GATE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R11]
        take_ext |-> verbose_join_option_in)
        else $error("trace frame while option off");
    AST_EXT_CMD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
        (suppress_in_cmd_mode_in && command_mode_in && idle && ext_valid_in && !rsp_valid_in
         && !node_valid_in) |=> ext_dropped_out)
        else $error("trace frame not suppressed");
    AST_NODE_MAKER: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R2]
        take_node |=> {body_reg[30], body_reg[31]} == `FB_MAKER_CODE && body_len_reg == 6'd32)
        else $error("maker code misplaced");
    AST_CKSUM_END: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R15]
        (state_reg == ST_CKSUM && fire) |=> state_reg == ST_IDLE)
        else $error("checksum not last byte");
endmodule : api_response_frame_builder

// [shared/frame_builder_defs.svh]
`ifndef FRAME_BUILDER_DEFS_SVH
`define FRAME_BUILDER_DEFS_SVH

`define FB_DELIM 8'h7E
`define FB_TYPE_NODE_ID 8'h95
`define FB_TYPE_REMOTE_RSP 8'h97
`define FB_TYPE_EXT_STATUS 8'h98
`define FB_NET_ADDR_UNKNOWN 16'hFFFE
`define FB_CKSUM_BASE 8'hFF
`define FB_ST_JOIN_START 8'h00
// Arbitrary neutral maker code for the node identification frame
`define FB_MAKER_CODE 16'hA5A5
`define FB_NODE_ID_BODY_LEN 6'd29
`define FB_MAX_PAYLOAD 5'd16
`define FB_FIFO_DEPTH 8
`define FB_HDR_LEN 6'd4
`define FB_RSP_FIXED_LEN 6'd15
`define FB_EXT_FIXED_LEN 6'd2

`endif

// [shared/frame_builder_pkg.sv]
package frame_builder_pkg;
    typedef struct packed {
        logic [7:0] frame_id;
        logic [63:0] addr64;
        logic [15:0] addr16;
        logic addr16_known;
        logic [15:0] cmd_name;
        logic [7:0] status;
        logic [4:0] data_len;
        logic [127:0] data;
    } remote_rsp_t;

    typedef struct packed {
        logic [7:0] code;
        logic [4:0] data_len;
        logic [127:0] data;
    } ext_status_t;

    typedef struct packed {
        logic [63:0] addr64;
        logic [15:0] addr16;
        logic [7:0] rx_opts;
        logic [15:0] remote16;
        logic [63:0] remote64;
        logic [15:0] name;
        logic [15:0] parent16;
        logic [7:0] dev_type;
        logic [7:0] src_event;
        logic [15:0] profile;
    } node_id_t;

    typedef enum logic [2:0] {
        RSP_OK = 3'h0,
        RSP_ERROR = 3'h1,
        RSP_BAD_CMD = 3'h2,
        RSP_BAD_PARAM = 3'h3,
        RSP_TX_FAIL = 3'h4
    } rsp_status_t;
endpackage : frame_builder_pkg

// [rtl/byte_fifo.sv]
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign in_ready_out = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_out = (count_reg != '0);
    assign out_data_out = mem[rd_ptr_reg];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
            end
            if (pop) begin
                rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
            end
            count_reg <= (AW+1)'(count_reg + push - pop);
        end
    end
endmodule : byte_fifo

// [dv/host_sink.sv]
`timescale 1ns/10ps
module host_sink (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic valid_in,
    input wire logic [7:0] data_in,
    input wire logic [1:0] mode_in,
    output logic ready_out
);
    logic [7:0] rx_q[$];
    int unsigned tick = 0;
    initial ready_out = 1'b0;
    // Mode 0 prompt, 1 ready one cycle in three, 2 stalled
    always @(negedge clk_in) begin
        tick <= tick + 1;
        ready_out <= rst_n_in && (mode_in == 2'd0 || (mode_in == 2'd1 && tick % 3 == 0));
    end
    // Raw capture of any number of frames; bytes are compared later, one by one, against the expected queue
    always @(posedge clk_in) begin
        if (rst_n_in && valid_in === 1'b1 && ready_out) begin
            rx_q.push_back(data_in);
        end
    end
endmodule : host_sink

// [dv/tb.sv]
`timescale 1ns/10ps
`include "frame_builder_defs.svh"
module tb;
    import frame_builder_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rsp_v = 1'b0, ext_v = 1'b0, node_v = 1'b0;
    logic vj = 1'b0, cm = 1'b0, sup = 1'b0, drop_seen = 1'b0;
    logic rsp_rdy, ext_rdy, node_rdy, tx_v, tx_rdy, dropped;
    logic [7:0] tx_d;
    logic [1:0] mode = 2'd0;
    remote_rsp_t r = '0;
    ext_status_t e = '0;
    node_id_t nd = '0;
    logic [7:0] body_q[$], exp_q[$];
    int mismatches = 0, checked = 0;
    always #2 clk = ~clk;
    api_response_frame_builder api_response_frame_builder_inst (.clk_in(clk), .rst_n_in(rst_n),
        .rsp_valid_in(rsp_v), .rsp_ready_out(rsp_rdy), .rsp_in(r), .ext_valid_in(ext_v),
        .ext_ready_out(ext_rdy), .ext_in(e), .node_valid_in(node_v), .node_ready_out(node_rdy),
        .node_in(nd), .verbose_join_option_in(vj), .command_mode_in(cm),
        .suppress_in_cmd_mode_in(sup), .tx_valid_out(tx_v), .tx_ready_in(tx_rdy),
        .tx_data_out(tx_d), .ext_dropped_out(dropped));
    host_sink host_sink_inst (.clk_in(clk), .rst_n_in(rst_n), .valid_in(tx_v), .data_in(tx_d),
        .mode_in(mode), .ready_out(tx_rdy));
    always @(posedge clk) begin
        if (dropped === 1'b1) drop_seen <= 1'b1;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    function automatic logic sel_ready(input int k);
        return k == 0 ? rsp_rdy : (k == 1 ? ext_rdy : node_rdy);
    endfunction : sel_ready
    // Request held from a falling edge until the rising edge that sees ready
    task automatic send(input int k);
        int n;
        @(negedge clk);
        rsp_v = (k == 0);
        ext_v = (k == 1);
        node_v = (k == 2);
        for (n = 0; n < 400 && sel_ready(k) !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        {rsp_v, ext_v, node_v} = 3'b000;
    endtask : send
    // Pushes the n leading bytes of a left-aligned value
    task automatic push(input logic [127:0] v, input int n);
        for (int i = 0; i < n; i++) body_q.push_back(v[127-8*i -: 8]);
    endtask : push
    task automatic close_frame();
        logic [7:0] s;
        s = 8'h00;
        foreach (body_q[i]) s += body_q[i];
        exp_q.push_back(`FB_DELIM);
        exp_q.push_back(8'h00);
        exp_q.push_back(8'(body_q.size()));
        foreach (body_q[i]) exp_q.push_back(body_q[i]);
        exp_q.push_back(`FB_CKSUM_BASE - s);
        body_q.delete();
    endtask : close_frame
    task automatic rsp_frame();
        body_q.push_back(`FB_TYPE_REMOTE_RSP);
        body_q.push_back(r.frame_id);
        push({r.addr64, 64'h0}, 8);
        push({(r.addr16_known ? r.addr16 : `FB_NET_ADDR_UNKNOWN), 112'h0}, 2);
        push({r.cmd_name, 112'h0}, 2);
        body_q.push_back(r.status);
        push(r.data, int'(r.data_len));
        close_frame();
    endtask : rsp_frame
    task automatic expect_all(input string name);
        int n;
        for (n = 0; n < 3000 && host_sink_inst.rx_q.size() < exp_q.size(); n++) @(negedge clk);
        repeat (4) @(negedge clk);
        check({name, " size"}, 16'(host_sink_inst.rx_q.size()), 16'(exp_q.size()));
        foreach (exp_q[i]) begin
            if (i < host_sink_inst.rx_q.size()) check(name, host_sink_inst.rx_q[i], exp_q[i]);
        end
        host_sink_inst.rx_q.delete();
        exp_q.delete();
        $display("test %s done", name);
    endtask : expect_all
    task automatic t_query_twice();
        r = '{8'h55, 64'h0013_A200_4052_2BAA, 16'h7D84, 1'b1, 16'h534C, 8'h00, 5'd4,
            {32'h4052_2BAA, 96'h0}};
        send(0);
        rsp_frame();
        send(0);
        rsp_frame();
        expect_all("query_twice");
    endtask : t_query_twice
    task automatic t_status_codes();
        mode = 2'd1;
        for (int s = 0; s < 5; s++) begin
            r = '{8'(8'h10 + s), 64'h1122_3344_5566_7788, 16'h0000, 1'b0, 16'h4142,
                8'(rsp_status_t'(s)), 5'd0, 128'h0};
            send(0);
            rsp_frame();
            expect_all("status_write");
        end
        mode = 2'd0;
    endtask : t_status_codes
    task automatic t_stall();
        r = '{8'h77, 64'h0102_0304_0506_0708, 16'hBEEF, 1'b1, 16'h5A5A, 8'h01, 5'd16,
            128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F};
        mode = 2'd2;
        send(0);
        rsp_frame();
        repeat (60) @(negedge clk);
        check("ready_while_busy", 16'(rsp_rdy), 16'h0000);
        check("tx_valid_held", 16'(tx_v), 16'h0001);
        mode = 2'd1;
        expect_all("stall_drain");
        mode = 2'd0;
    endtask : t_stall
    task automatic t_node();
        nd = '{64'h0013_A200_4052_2BAA, 16'h7D84, 8'h02, 16'h7D84, 64'h0013_A200_4052_2BAA,
            16'h2000, 16'hFFFE, 8'h01, 8'h01, 16'h1234};
        send(2);
        body_q.push_back(`FB_TYPE_NODE_ID);
        for (int i = 0; i < $bits(nd) / 8; i++) body_q.push_back(nd[$bits(nd)-1-8*i -: 8]);
        push({`FB_MAKER_CODE, 112'h0}, 2);
        close_frame();
        expect_all("node_id");
    endtask : t_node
    task automatic t_ext(input string name, input logic v, c, p, input logic out);
        vj = v;
        cm = c;
        sup = p;
        drop_seen = 1'b0;
        e = '{`FB_ST_JOIN_START, 5'd1, {8'h03, 120'h0}};
        send(1);
        if (out) begin
            body_q.push_back(`FB_TYPE_EXT_STATUS);
            body_q.push_back(e.code);
            body_q.push_back(8'h03);
            close_frame();
            expect_all(name);
        end else begin
            repeat (40) @(negedge clk);
            check({name, " dropped"}, 16'(drop_seen), 16'h0001);
            check({name, " silent"}, 16'(host_sink_inst.rx_q.size()), 16'h0000);
            $display("test %s done", name);
        end
    endtask : t_ext
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        check("idle_tx_valid", 16'(tx_v), 16'h0000);
        t_query_twice();
        t_status_codes();
        t_stall();
        t_node();
        t_ext("ext_on", 1'b1, 1'b0, 1'b1, 1'b1);
        t_ext("ext_off", 1'b0, 1'b0, 1'b1, 1'b0);
        t_ext("ext_cmd_new", 1'b1, 1'b1, 1'b1, 1'b0);
        t_ext("ext_cmd_old", 1'b1, 1'b1, 1'b0, 1'b1);
        conclude();
    end
endmodule : tb
